// File: hdl/wdt_pkg.sv
// constants, register map and field layouts of the watchdog interval timer
// assumes one 200 MHz system clock and an AXI4-Lite master for software access
//
// Operation
// - watchdog reset or plain interval timer use
// - slow power modes force system clock twelfth
// - run field 01 freezes the countdown
// - run field 10 decrements once per tick
// - run field 00 or 11 counts like 10
// - reset-enable 01 never resets the chip
// - reset-enable 10 resets chip on underflow
// - reset-enable 00 or 11 acts like 10
// - run and reset-enable fields reset to 01
// - cause bit: pin reset clears, underflow with reset enabled sets
// - clock select: sys/12, fast/32, /1024, /16384
// - countdown resets to FF, rewritable while counting
// - underflow sets flag, interrupt service clears it
package wdt_pkg;

    // ****************************************************************
    // register map: printed offsets are indexes, byte address is 4x
    // ****************************************************************
    localparam logic [7:0]  CTRL_INDEX       = 8'hA1;
    localparam logic [7:0]  COUNT_INDEX      = 8'hA2;
    localparam logic [7:0]  IRQ_STATUS_INDEX = 8'hB0;
    localparam logic [7:0]  IRQ_MASK_INDEX   = 8'hB1;
    localparam logic [11:0] CTRL_ADDR        = {2'h0, CTRL_INDEX, 2'h0};
    localparam logic [11:0] COUNT_ADDR       = {2'h0, COUNT_INDEX, 2'h0};
    localparam logic [11:0] IRQ_STATUS_ADDR  = {2'h0, IRQ_STATUS_INDEX, 2'h0};
    localparam logic [11:0] IRQ_MASK_ADDR    = {2'h0, IRQ_MASK_INDEX, 2'h0};

    // ****************************************************************
    // field codes
    // ****************************************************************
    localparam logic [1:0] RUN_OFF    = 2'h1;
    localparam logic [1:0] RUN_ON     = 2'h2;
    localparam logic [1:0] REN_OFF    = 2'h1;
    localparam logic [1:0] REN_ON     = 2'h2;
    localparam logic [1:0] CSEL_SYS12 = 2'h0;
    localparam logic [1:0] CSEL_FAST1 = 2'h1;
    localparam logic [1:0] CSEL_FAST2 = 2'h2;
    localparam logic [1:0] CSEL_FAST3 = 2'h3;
    localparam int unsigned UF_BIT    = 0;

    // control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic [1:0] timer_run_field;
        logic [1:0] reset_enable_field;
        logic       reset_cause_flag;
        logic       reserved;
        logic [1:0] count_clock_select;
    } ctrl_s;

    // ****************************************************************
    // reset values and division counts
    // ****************************************************************
    localparam ctrl_s      CTRL_RESET  = '{RUN_OFF, REN_OFF, 1'b0, 1'b0, CSEL_SYS12};
    localparam logic [7:0] COUNT_RESET = 8'hFF;
    localparam logic [3:0] SYS_DIV     = 4'hC;
    localparam logic [15:0] FAST_DIV_1 = 16'h0020;
    localparam logic [15:0] FAST_DIV_2 = 16'h0400;
    localparam int unsigned FAST_DIV_3 = 16384;

    // ****************************************************************
    // bus answers
    // ****************************************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: hdl/count_tick_gen.sv
// prescaler producing the watchdog counting tick from system or fast clock
// assumes fast_tick is a one-cycle pulse per fast clock period, same domain
`timescale 1ns/1ps
module count_tick_gen #(
    parameter int unsigned FAST_DIV_SLOWEST = wdt_pkg::FAST_DIV_3
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       fast_tick,
    input  wire logic [1:0] clk_sel,
    output logic            tick
);

    logic [3:0]  sys_cnt_r;
    logic [15:0] fast_cnt_r;
    logic [15:0] div_m1;
    logic        sys_tick;
    logic        fast_wrap;

    // ****************************************************************
    // dividers
    // ****************************************************************

    // system clock divided by twelve, free running
    always_ff @(posedge aclk) begin
        if (!aresetn || sys_tick) begin
            sys_cnt_r <= 4'h0;
        end else begin
            sys_cnt_r <= sys_cnt_r + 4'h1;
        end
    end

    assign sys_tick = (sys_cnt_r == wdt_pkg::SYS_DIV - 4'h1);

    // fast divisor from the select; >= wrap keeps a shrinking divisor safe
    always_comb begin
        case (clk_sel)
            wdt_pkg::CSEL_FAST1: div_m1 = wdt_pkg::FAST_DIV_1 - 16'h1;
            wdt_pkg::CSEL_FAST2: div_m1 = wdt_pkg::FAST_DIV_2 - 16'h1;
            default:             div_m1 = 16'(FAST_DIV_SLOWEST - 1);
        endcase
    end

    assign fast_wrap = fast_tick && (fast_cnt_r >= div_m1);

    // fast clock prescaler counts fast ticks only
    always_ff @(posedge aclk) begin
        if (!aresetn || fast_wrap) begin
            fast_cnt_r <= 16'h0;
        end else if (fast_tick) begin
            fast_cnt_r <= fast_cnt_r + 16'h1;
        end
    end

    assign tick = (clk_sel == wdt_pkg::CSEL_SYS12) ? sys_tick : fast_wrap;

    a_sys_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_sel == wdt_pkg::CSEL_SYS12) && tick |=> !sys_tick [*8])
        else $error("system divided tick came early");

endmodule

// File: hdl/watchdog_interval_timer.sv
// watchdog interval timer with AXI4-Lite register slave
// assumes chip_reset_req feeds the chip reset that drives aresetn back here,
// and irq_ack pulses when the interrupt controller services this source
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module watchdog_interval_timer #(
    parameter int unsigned FAST_DIV_SLOWEST = wdt_pkg::FAST_DIV_3
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        fast_tick,
    input  wire logic        slow_all_mode,
    input  wire logic        slow_peripheral_mode,
    input  wire logic        ext_pin_reset,
    input  wire logic        irq_ack,
    output logic             irq,
    output logic             chip_reset_req
);

    logic [11:0]       aw_addr_r;
    logic              aw_held_r;
    logic [31:0]       w_data_r;
    logic [3:0]        w_strb_r;
    logic              w_held_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              rvalid_r;
    logic [1:0]        rresp_r;
    logic [31:0]       rdata_r;
    logic              wr_fire;
    logic              wr_ctrl;
    logic              wr_cnt;
    logic              wr_stat;
    logic              wr_mask;
    logic              wr_err;
    logic              rd_fire;
    logic [31:0]       rd_val;
    logic              rd_err;
    wdt_pkg::ctrl_s    ctrl_r;
    wdt_pkg::ctrl_s    ctrl_view;
    logic              cause_r;
    logic [7:0]        cnt_r;
    logic [7:0]        status_r;
    logic [7:0]        status_nxt;
    logic [7:0]        mask_r;
    logic              chip_reset_r;
    logic              pin_s1_r;
    logic              pin_s2_r;
    logic              pin_s3_r;
    logic              pin_seen;
    logic [1:0]        eff_sel;
    logic              sel_tick;
    logic              counting;
    logic              count_tick;
    logic              underflow;
    logic              reset_en;

    // ****************************************************************
    // AXI4-Lite write channels
    // ****************************************************************

    // each address and data beat is parked until both are here
    assign awready = !aw_held_r && !bvalid_r;
    assign wready  = !w_held_r && !bvalid_r;
    assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 12'h000;
        end else if (awvalid && awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= awaddr;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (wvalid && wready) begin
            w_held_r <= 1'b1;
            w_data_r <= wdata;
            w_strb_r <= wstrb;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end
    end

    // write decode; registers live in byte lane 0, other lanes are ignored
    always_comb begin
        wr_ctrl = 1'b0;
        wr_cnt  = 1'b0;
        wr_stat = 1'b0;
        wr_mask = 1'b0;
        wr_err  = 1'b0;
        if (aw_addr_r == wdt_pkg::CTRL_ADDR) begin
            wr_ctrl = wr_fire && w_strb_r[0];
        end else if (aw_addr_r == wdt_pkg::COUNT_ADDR) begin
            wr_cnt = wr_fire && w_strb_r[0];
        end else if (aw_addr_r == wdt_pkg::IRQ_STATUS_ADDR) begin
            wr_stat = wr_fire && w_strb_r[0];
        end else if (aw_addr_r == wdt_pkg::IRQ_MASK_ADDR) begin
            wr_mask = wr_fire && w_strb_r[0];
        end else begin
            wr_err = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= wdt_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_err ? wdt_pkg::RESP_SLVERR : wdt_pkg::RESP_OKAY;
        end else if (bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ****************************************************************
    // AXI4-Lite read channels
    // ****************************************************************
    assign arready = !rvalid_r;
    assign rd_fire = arvalid && arready;
    assign rvalid  = rvalid_r;
    assign rresp   = rresp_r;
    assign rdata   = rdata_r;

    // control view carries the cause bit and a zero reserved bit
    always_comb begin
        ctrl_view                  = ctrl_r;
        ctrl_view.reset_cause_flag = cause_r;
        ctrl_view.reserved         = 1'b0;
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b0;
        if (araddr == wdt_pkg::CTRL_ADDR) begin
            rd_val = {24'h00_0000, ctrl_view};
        end else if (araddr == wdt_pkg::COUNT_ADDR) begin
            rd_val = {24'h00_0000, cnt_r};
        end else if (araddr == wdt_pkg::IRQ_STATUS_ADDR) begin
            rd_val = {24'h00_0000, status_r};
        end else if (araddr == wdt_pkg::IRQ_MASK_ADDR) begin
            rd_val = {24'h00_0000, mask_r};
        end else begin
            rd_err = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r  <= wdt_pkg::RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
        end else if (rd_fire) begin
            rvalid_r <= 1'b1;
            rresp_r  <= rd_err ? wdt_pkg::RESP_SLVERR : wdt_pkg::RESP_OKAY;
            rdata_r  <= rd_val;
        end else if (rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ****************************************************************
    // control register
    // ****************************************************************

    // all fields writable except cause, which reads back live, and reserved, which reads zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= wdt_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= wdt_pkg::ctrl_s'(w_data_r[7:0]);  // no code check
        end
    end

    // ****************************************************************
    // counting clock and countdown
    // ****************************************************************

    // slow modes leave only the system clock path usable
    assign eff_sel = (slow_all_mode || slow_peripheral_mode) ?
                     wdt_pkg::CSEL_SYS12 : ctrl_r.count_clock_select;

    count_tick_gen #(
        .FAST_DIV_SLOWEST (FAST_DIV_SLOWEST)
    ) u_tick (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .fast_tick (fast_tick),
        .clk_sel   (eff_sel),
        .tick      (sel_tick)
    );

    // only 01 stops; a single flipped bit out of 10 keeps the timer alive
    assign counting   = (ctrl_r.timer_run_field != wdt_pkg::RUN_OFF);
    assign count_tick = sel_tick && counting;
    assign underflow  = count_tick && (cnt_r == 8'h00) && !wr_cnt;
    assign reset_en   = (ctrl_r.reset_enable_field != wdt_pkg::REN_OFF);

    // a software reload wins over a tick in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= wdt_pkg::COUNT_RESET;
        end else if (wr_cnt) begin
            cnt_r <= w_data_r[7:0];
        end else if (count_tick) begin
            cnt_r <= cnt_r - 8'h01;  // 00 wraps to FF
        end
    end

    // ****************************************************************
    // chip reset and reset cause
    // ****************************************************************

    // request holds until the chip reset comes back on aresetn
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chip_reset_r <= 1'b0;
        end else if (underflow && reset_en) begin
            chip_reset_r <= 1'b1;
        end
    end

    assign chip_reset_req = chip_reset_r;

    // pin synchroniser is not reset so a pin reset is still seen during it
    always_ff @(posedge aclk) begin
        pin_s1_r <= ext_pin_reset;
        pin_s2_r <= pin_s1_r;
        pin_s3_r <= pin_s2_r;
    end

    assign pin_seen = pin_s2_r && pin_s3_r;

    // cause must survive its own reset, so aresetn does not touch it
    always_ff @(posedge aclk) begin
        if (pin_seen) begin
            cause_r <= 1'b0;
        end else if (underflow && reset_en) begin
            cause_r <= 1'b1;
        end
    end

    // ****************************************************************
    // interrupt status and mask
    // ****************************************************************

    // set beats both the write-one clear and the service clear
    always_comb begin
        status_nxt = status_r;
        if (wr_stat) begin
            status_nxt = status_nxt & ~w_data_r[7:0];
        end
        if (irq_ack) begin
            status_nxt[wdt_pkg::UF_BIT] = 1'b0;
        end
        if (underflow) begin
            status_nxt[wdt_pkg::UF_BIT] = 1'b1;
        end
        status_nxt[7:1] = 7'h00;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_r <= 8'h00;
        end else begin
            status_r <= status_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_r <= 8'h00;
        end else if (wr_mask) begin
            mask_r <= {7'h00, w_data_r[0]};
        end
    end

    // interval timer use: reset off, interrupt unmasked
    assign irq = |(status_r & mask_r);

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_reset_fields: assert property (disable iff (1'b0)
        !aresetn |=> ctrl_r.timer_run_field == wdt_pkg::RUN_OFF
                     && ctrl_r.reset_enable_field == wdt_pkg::REN_OFF)
        else $error("fields not 01 after reset");
    a_count_reset: assert property (disable iff (1'b0)
        !aresetn |=> cnt_r == 8'hFF)
        else $error("countdown not FF after reset");
    a_frozen_hold: assert property (
        ctrl_r.timer_run_field == wdt_pkg::RUN_OFF && !wr_cnt |=> $stable(cnt_r))
        else $error("stopped timer changed count");
    a_count_step: assert property (
        ctrl_r.timer_run_field == wdt_pkg::RUN_ON && sel_tick && !wr_cnt
        |=> cnt_r == $past(cnt_r) - 8'h01)
        else $error("running timer missed a step");
    a_redundant_run: assert property (
        ctrl_r.timer_run_field[1] == ctrl_r.timer_run_field[0] && sel_tick && !wr_cnt
        |=> cnt_r == $past(cnt_r) - 8'h01)
        else $error("redundant run code stopped timer");
    a_slow_source: assert property (
        slow_all_mode || slow_peripheral_mode |-> eff_sel == wdt_pkg::CSEL_SYS12)
        else $error("slow mode used fast source");
    a_no_reset_off: assert property (
        ctrl_r.reset_enable_field == wdt_pkg::REN_OFF && underflow && !chip_reset_r
        |=> !chip_reset_req)
        else $error("reset raised while disabled");
    a_reset_on: assert property (
        ctrl_r.reset_enable_field == wdt_pkg::REN_ON && underflow
        |=> chip_reset_req [*2])
        else $error("no chip reset on underflow");
    a_reset_redundant: assert property (
        ctrl_r.reset_enable_field[1] == ctrl_r.reset_enable_field[0] && underflow
        |=> chip_reset_req && cause_r)
        else $error("redundant enable code missed reset");
    a_cause_set: assert property (
        underflow && reset_en && !pin_seen |=> cause_r)
        else $error("cause bit not set by underflow");
    a_flag_set: assert property (
        underflow |=> status_r[wdt_pkg::UF_BIT] ##1 status_r[wdt_pkg::UF_BIT] || irq_ack
                      || $past(irq_ack) || $past(wr_stat))
        else $error("underflow flag not raised");
    a_flag_ack: assert property (
        irq_ack && !underflow |=> !status_r[wdt_pkg::UF_BIT])
        else $error("service did not clear flag");

    c_interval_irq: cover property (underflow && !reset_en ##[1:3] irq);
    c_chip_reset: cover property (underflow && reset_en);
    c_reload_run: cover property (wr_cnt && counting);
    c_slow_mode: cover property (slow_all_mode && count_tick);

endmodule

// File: test/tb_watchdog_interval_timer.sv
// self-checking bench for the watchdog interval timer
// assumes the design under hdl/ and its package; drives every port directly
`timescale 1ns/1ps
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_watchdog_interval_timer;
    logic        aclk = 1'b0, aresetn = 1'b0, fast_tick = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq, chip_reset_req;
    logic [1:0]  bresp, rresp;
    logic        slow_all_mode = 1'b0, slow_peripheral_mode = 1'b0;
    logic        ext_pin_reset = 1'b1, irq_ack = 1'b0;
    int          miscompares = 0, comparisons = 0, cycles = 0;

    // slowest fast divider shrunk so the longest interval stays short
    watchdog_interval_timer #(.FAST_DIV_SLOWEST(64)) watchdog_interval_timer_inst (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .fast_tick(fast_tick), .slow_all_mode(slow_all_mode),
        .slow_peripheral_mode(slow_peripheral_mode), .ext_pin_reset(ext_pin_reset),
        .irq_ack(irq_ack), .irq(irq), .chip_reset_req(chip_reset_req));

    // ****************************************************************
    // clock, fast tick and hang guard
    // ****************************************************************
    always #2.5 aclk = ~aclk;
    // fast tick pulses every second cycle, so fast/N ticks every 2N cycles
    always @(posedge aclk) fast_tick <= ~fast_tick;
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            stop_test();
        end
    end

    // ****************************************************************
    // bus and reset tasks
    // ****************************************************************
    // handshakes are judged on the values that stood at each rising edge
    task automatic axi_write(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        logic got;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        got = 1'b0;
        while (!got) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                got = 1'b1;
                r = bresp;
            end
        end
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
        logic got;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        got = 1'b0;
        while (!got) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                got = 1'b1;
                d = rdata[7:0];
                r = rresp;
            end
        end
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        `CHECK(r, wdt_pkg::RESP_OKAY)
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        `CHECK(d, exp)
    endtask

    // pin selects whether the external reset pin joins the bus reset
    task automatic do_reset(input logic pin);
        @(posedge aclk);
        aresetn <= 1'b0;
        ext_pin_reset <= pin;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        ext_pin_reset <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic test_reset_values();
        logic [7:0] d;
        logic [1:0] r;
        rd(wdt_pkg::CTRL_ADDR, 8'h50);
        rd(wdt_pkg::COUNT_ADDR, 8'hFF);
        rd(wdt_pkg::IRQ_STATUS_ADDR, 8'h00);
        axi_read(12'h000, d, r);
        `CHECK({r, d}, {wdt_pkg::RESP_SLVERR, 8'h00})
        axi_write(12'h004, 8'h5A, r);
        `CHECK(r, wdt_pkg::RESP_SLVERR)
        $display("test reset_values done");
    endtask

    // count 1 gives two ticks: nothing before quiet, the flag within total
    task automatic interval(input logic [7:0] ctl, input int quiet, input int total,
                            input logic fire, input logic rst);
        int n;
        wr(wdt_pkg::IRQ_MASK_ADDR, 8'h01);
        wr(wdt_pkg::IRQ_STATUS_ADDR, 8'h01);
        wr(wdt_pkg::COUNT_ADDR, 8'h01);
        wr(wdt_pkg::CTRL_ADDR, ctl);
        repeat (quiet) @(negedge aclk);
        `CHECK(irq, 1'b0)
        for (n = 0; n < total && irq !== 1'b1; n++) @(negedge aclk);
        `CHECK(irq, fire)
        `CHECK(chip_reset_req, rst)
        if (rst) begin
            do_reset(1'b0);
            `CHECK(chip_reset_req, 1'b0)
            rd(wdt_pkg::CTRL_ADDR, 8'h58);
        end else begin
            wr(wdt_pkg::CTRL_ADDR, 8'h50);   // back to legal stop code
        end
        $display("test interval %h done", ctl);
    endtask

    // masking and hardware clear on service, checked by status reads
    task automatic test_irq();
        interval(8'h90, 8, 40, 1'b1, 1'b0);
        wr(wdt_pkg::IRQ_MASK_ADDR, 8'h00);
        @(negedge aclk);
        `CHECK(irq, 1'b0)
        wr(wdt_pkg::IRQ_MASK_ADDR, 8'h01);
        rd(wdt_pkg::IRQ_STATUS_ADDR, 8'h01);
        @(posedge aclk);
        irq_ack <= 1'b1;
        @(posedge aclk);
        irq_ack <= 1'b0;
        rd(wdt_pkg::IRQ_STATUS_ADDR, 8'h00);
        `CHECK(irq, 1'b0)
        $display("test irq done");
    endtask

    // reload every 34 cycles against a 37 to 48 cycle interval keeps it quiet
    task automatic test_kick();
        wr(wdt_pkg::COUNT_ADDR, 8'h03);
        wr(wdt_pkg::CTRL_ADDR, 8'h90);
        repeat (8) begin
            repeat (30) @(posedge aclk);
            wr(wdt_pkg::COUNT_ADDR, 8'h03);
        end
        `CHECK(irq, 1'b0)
        `CHECK(chip_reset_req, 1'b0)
        wr(wdt_pkg::CTRL_ADDR, 8'h50);
        $display("test kick done");
    endtask

    task automatic stop_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        do_reset(1'b1);
        test_reset_values();
        interval(8'h50, 40, 40, 1'b0, 1'b0);
        rd(wdt_pkg::COUNT_ADDR, 8'h01);
        interval(8'h90, 8, 40, 1'b1, 1'b0);
        interval(8'h10, 8, 40, 1'b1, 1'b0);
        interval(8'hD0, 8, 40, 1'b1, 1'b0);
        interval(8'h91, 50, 150, 1'b1, 1'b0);
        interval(8'h92, 1500, 2800, 1'b1, 1'b0);
        interval(8'h93, 100, 300, 1'b1, 1'b0);
        slow_all_mode <= 1'b1;
        interval(8'h93, 8, 40, 1'b1, 1'b0);
        slow_all_mode <= 1'b0;
        slow_peripheral_mode <= 1'b1;
        interval(8'h92, 8, 40, 1'b1, 1'b0);
        slow_peripheral_mode <= 1'b0;
        test_irq();
        test_kick();
        interval(8'hA0, 8, 40, 1'b1, 1'b1);
        interval(8'h80, 8, 40, 1'b1, 1'b1);
        interval(8'hB0, 8, 40, 1'b1, 1'b1);
        do_reset(1'b1);
        rd(wdt_pkg::CTRL_ADDR, 8'h50);
        stop_test();
    end
endmodule
